// >>> hw/mcal_pkg.sv
// Purpose: shared types and constants for the direct command sequencer
// Assumes: 100 MHz system clock
// Notes: times are in ns, cycle counts derive from them
package mcal_pkg;
    // command codes as delivered by the link side
    typedef enum logic [3:0] {
        CMD_MEAS_AMP, CMD_SQUELCH, CMD_GAIN_RST, CMD_ADJ_REG,
        CMD_CAL_MOD, CMD_CAL_ANT, CMD_MEAS_PHASE, CMD_CLR_RSSI,
        CMD_TRANSP, CMD_MEAS_SUP, CMD_NONE
    } cmd_t;

    typedef struct packed {
        cmd_t cmd;
        logic chain;    // more commands follow in this transaction
    } cmd_word_t;

    // analog front end controls
    typedef struct packed {
        logic tx_on;
        logic rx_on;
        logic amp_det;
        logic phase_det;
        logic sup_div;
        logic adc_rel;
        logic adc_start;
        logic mod_cal;
        logic ant_cal;
        logic squelch;
    } ana_ctrl_t;

    localparam int CLK_MHZ       = 100;
    localparam int T_MEAS_NS     = 25000;
    localparam int T_SQ_NS       = 500000;
    localparam int T_REG_STEP_NS = 300000;
    localparam int T_REG_NS      = 5000000;
    localparam int T_MOD_NS      = 275000;
    localparam int T_ANT_NS      = 250000;
    localparam int MEAS_CYC      = T_MEAS_NS * CLK_MHZ / 1000;
    localparam int TMR_W         = 20;
    localparam int TMR_CYC_MAX   = 1048575;

    // regulator steps: max 5.1/3.4 V down to 3.9/2.4 V, ten steps
    localparam logic [3:0] REG_CODE_MAX = 4'h0a;
    localparam logic [3:0] REG_CODE_MIN = 4'h0;
    localparam logic [3:0] REG_CODE_RST = 4'h0a;

    // a/d codes: amplitude full scale, phase saturation
    localparam logic [7:0] AMP_FULL_CODE = 8'he6;
    localparam logic [7:0] PHASE_SAT_LO  = 8'hff;
    localparam logic [7:0] PHASE_SAT_HI  = 8'h00;
    localparam logic [7:0] PHASE_MID     = 8'h80;
    localparam logic [7:0] BYTE_RST      = 8'h00;
endpackage

// >>> hw/measure_calibrate_direct_cmds.sv
// Purpose: sequencer for measure and calibrate direct commands
// Assumes: link domain captures commands, analog side on clk_sys_i
// Notes: a/d scaling is analog; this block stores and clamps codes
// How it works
// - amplitude command enables tx and detector, absolute a/d, stores code
// - amplitude code scale fixed by analog; full scale reads e6h
// - these commands need enable bit and stable oscillator
// - measure, regulator and modulation commands unchainable; raise irq at end
// - squelch, gain reset and rssi clear raise no irq
// - gain reset and rssi clear may be chained
// - squelch needs tx and rx on; runs only with rx inactive; 500 us
// - gain reset aborts squelch, clears it, loads manual gain
// - regulator adjust starts at max setting with tx and rx on
// - every 300 us compare; gap too small lowers setting one step
// - regulator adjust stops on enough gap or minimum setting
// - rejected with external regulator select; ends within 5 ms
// - modulation calibration writes result back within 275 us
// - antenna calibration trims tuning caps, ends within 250 us
// - phase command enables tx and phase detector, relative a/d
// - phase saturates to ffh below 30 deg, 00h above 150
// - phase step 0.468 deg, 90 deg mid range, higher code less phase
// - amplitude, phase, supply measurements end within 25 us
// - rx active rising clears rssi and restarts peak hold
// - rssi clear command clears rssi while rx active
// - transparent mode from ss rising edge while ss high
// - supply measure selects supply by two bits, absolute a/d
`timescale 1ns/1ps
module measure_calibrate_direct_cmds
    import mcal_pkg::*;
#(
    parameter int SQ_CYC   = T_SQ_NS * CLK_MHZ / 1000,
    parameter int STEP_CYC = T_REG_STEP_NS * CLK_MHZ / 1000,
    parameter int REG_CYC  = T_REG_NS * CLK_MHZ / 1000,
    parameter int MOD_CYC  = T_MOD_NS * CLK_MHZ / 1000,
    parameter int ANT_CYC  = T_ANT_NS * CLK_MHZ / 1000
) (
    // clocks and reset
    input  wire logic      clk_sys_i,
    input  wire logic      rst_i,
    input  wire logic      clk_link_i,
    // link side command port (link clock)
    input  wire logic      cmd_stb_i,
    input  wire cmd_word_t cmd_word_i,
    output logic           link_busy_o,
    // slave select pin, asynchronous
    input  wire logic      ss_i,
    // configuration and status levels
    input  wire logic      op_en_i,
    input  wire logic      osc_ok_i,
    input  wire logic      tx_en_i,
    input  wire logic      rx_en_i,
    input  wire logic      reg_ext_sel_i,
    input  wire logic      supply_select_hi_i,
    input  wire logic      supply_select_lo_i,
    input  wire logic [7:0] rx_cfg4_gain_i,
    input  wire logic      mod_wr_i,
    input  wire logic [7:0] mod_wdata_i,
    // analog feedback
    input  wire logic      rx_active_i,
    input  wire logic      adc_done_i,
    input  wire logic [7:0] adc_data_i,
    input  wire logic      phase_lt30_i,
    input  wire logic      phase_gt150_i,
    input  wire logic      reg_gap_ok_i,
    input  wire logic      sq_done_i,
    input  wire logic      mod_done_i,
    input  wire logic [7:0] mod_result_i,
    input  wire logic      ant_done_i,
    input  wire logic [7:0] ant_trim_i,
    // analog controls and results
    output ana_ctrl_t      ana_o,
    output logic [1:0]     supply_sel_o,
    output logic [7:0]     adc_result_o,
    output logic [3:0]     reg_setting_o,
    output logic [7:0]     mod_depth_o,
    output logic [7:0]     tuning_cap_pins_o,
    output logic [7:0]     gain_red_o,
    output logic           transparent_o,
    // event pulses and busy level
    output logic           cmd_irq_o,
    output logic           cmd_reject_o,
    output logic           rssi_clear_o,
    output logic           agc_reset_o,
    output logic           busy_o
);

    // refuse cycle counts that the timers cannot hold
    if (SQ_CYC < 1 || STEP_CYC < 1 || REG_CYC < 1 ||
        MOD_CYC < 1 || ANT_CYC < 1 || SQ_CYC > TMR_CYC_MAX ||
        STEP_CYC > TMR_CYC_MAX || REG_CYC > TMR_CYC_MAX ||
        MOD_CYC > TMR_CYC_MAX || ANT_CYC > TMR_CYC_MAX) begin : g_cyc_chk
        $error("cycle count out of range");
    end

    function automatic logic [TMR_W-1:0] cyc(input int n);
        cyc = TMR_W'(n);
    endfunction

    // link domain: hold word, toggle request until acknowledged
    logic      req_tgl_q, req_tgl_d;
    cmd_word_t word_q, word_d;
    logic      ack_m_q, ack_s_q;
    logic      ack_tgl_q;
    always_comb begin
        req_tgl_d = req_tgl_q;
        word_d    = word_q;
        if (cmd_stb_i && !link_busy_o) begin
            req_tgl_d = ~req_tgl_q;
            word_d    = cmd_word_i;
        end
    end
    always_ff @(posedge clk_link_i or posedge rst_i) begin
        if (rst_i) begin
            req_tgl_q <= 1'b0;
            word_q    <= '{cmd: CMD_NONE, chain: 1'b0};
            ack_m_q   <= 1'b0;
            ack_s_q   <= 1'b0;
        end else begin
            req_tgl_q <= req_tgl_d;
            word_q    <= word_d;
            ack_m_q   <= ack_tgl_q;
            ack_s_q   <= ack_m_q;
        end
    end
    assign link_busy_o = req_tgl_q ^ ack_s_q;

    // system domain synchronisers for request toggle and ss pin
    logic req_m_q, req_s_q, req_p_q;
    logic ss_m_q, ss_s_q, ss_p_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            req_m_q <= 1'b0;
            req_s_q <= 1'b0;
            req_p_q <= 1'b0;
            ss_m_q  <= 1'b0;
            ss_s_q  <= 1'b0;
            ss_p_q  <= 1'b0;
        end else begin
            req_m_q <= req_tgl_q;
            req_s_q <= req_m_q;
            req_p_q <= req_s_q;
            ss_m_q  <= ss_i;
            ss_s_q  <= ss_m_q;
            ss_p_q  <= ss_s_q;
        end
    end
    // word is stable in link domain while the toggle is pending
    logic new_cmd;
    cmd_t cmd;
    assign new_cmd = req_s_q ^ req_p_q;
    assign cmd     = word_q.cmd;

    typedef enum logic [2:0] {
        S_IDLE, S_MEAS, S_SQ, S_REG, S_MOD, S_ANT
    } state_t;
    state_t state_q, state_d;
    logic [TMR_W-1:0] tmr_q, tmr_d, tot_q, tot_d, mcnt_q, mcnt_d;
    logic [7:0] adc_q, adc_d, mod_q, mod_d, ant_q, ant_d, gain_q, gain_d;
    logic [3:0] reg_q, reg_d;
    ana_ctrl_t  ana_q, ana_d;
    logic ack_d, irq_d, rej_d, rclr_d, agc_d, arm_q, arm_d, tr_q, tr_d;
    logic irq_q, rej_q, rclr_q, agc_q, rxa_q;
    logic gate, chainable;

    // main sequencer
    always_comb begin
        state_d = state_q;
        tmr_d   = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        tot_d   = (tot_q != '0) ? tot_q - 1'b1 : tot_q;
        mcnt_d  = (state_q == S_MEAS) ? mcnt_q + 1'b1 : '0;
        adc_d   = adc_q;
        mod_d   = mod_wr_i ? mod_wdata_i : mod_q;
        ant_d   = ant_q;
        gain_d  = gain_q;
        reg_d   = reg_q;
        ana_d   = ana_q;
        ana_d.adc_start = 1'b0;
        ack_d   = ack_tgl_q;
        irq_d   = 1'b0;
        rej_d   = 1'b0;
        agc_d   = 1'b0;
        arm_d   = arm_q;
        tr_d    = tr_q;
        gate    = op_en_i && osc_ok_i;
        chainable = (cmd == CMD_GAIN_RST) || (cmd == CMD_CLR_RSSI);
        rclr_d  = rx_active_i && !rxa_q;
        // transparent mode on ss rising edge, held while ss high
        if (arm_q && ss_s_q && !ss_p_q) begin
            tr_d  = 1'b1;
            arm_d = 1'b0;
        end
        if (!ss_s_q) begin
            tr_d = 1'b0;
        end
        if (new_cmd) begin
            ack_d = ~ack_tgl_q;
            if (!gate || (word_q.chain && !chainable) ||
                (state_q != S_IDLE && cmd != CMD_GAIN_RST) ||
                (cmd == CMD_SQUELCH && !(tx_en_i && rx_en_i)) ||
                (cmd == CMD_ADJ_REG && reg_ext_sel_i)) begin
                rej_d = 1'b1;
            end else begin
                case (cmd)
                    CMD_MEAS_AMP, CMD_MEAS_PHASE, CMD_MEAS_SUP: begin
                        state_d = S_MEAS;
                        tmr_d   = cyc(MEAS_CYC);
                        ana_d.tx_on     = cmd != CMD_MEAS_SUP;
                        ana_d.amp_det   = cmd == CMD_MEAS_AMP;
                        ana_d.phase_det = cmd == CMD_MEAS_PHASE;
                        ana_d.sup_div   = cmd == CMD_MEAS_SUP;
                        ana_d.adc_rel   = cmd == CMD_MEAS_PHASE;
                        ana_d.adc_start = 1'b1;
                    end
                    CMD_SQUELCH: begin
                        if (!rx_active_i) begin
                            state_d = S_SQ;
                            tmr_d   = cyc(SQ_CYC);
                            ana_d.squelch = 1'b1;
                        end
                    end
                    CMD_GAIN_RST: begin
                        if (state_q == S_SQ) begin
                            state_d = S_IDLE;
                        end
                        ana_d.squelch = 1'b0;
                        agc_d  = 1'b1;
                        gain_d = rx_cfg4_gain_i;
                    end
                    CMD_ADJ_REG: begin
                        state_d = S_REG;
                        reg_d   = REG_CODE_MAX;
                        ana_d.tx_on = 1'b1;
                        ana_d.rx_on = 1'b1;
                        tmr_d   = cyc(STEP_CYC);
                        tot_d   = cyc(REG_CYC);
                    end
                    CMD_CAL_MOD: begin
                        state_d = S_MOD;
                        ana_d.tx_on   = 1'b1;
                        ana_d.mod_cal = 1'b1;
                        tmr_d   = cyc(MOD_CYC);
                    end
                    CMD_CAL_ANT: begin
                        state_d = S_ANT;
                        ana_d.ant_cal = 1'b1;
                        tmr_d   = cyc(ANT_CYC);
                    end
                    CMD_CLR_RSSI: begin
                        rclr_d = rx_active_i;
                    end
                    CMD_TRANSP: begin
                        arm_d = 1'b1;
                    end
                    default: begin
                        rej_d = 1'b1;
                    end
                endcase
            end
        end
        case (state_q)
            S_MEAS: begin
                if (adc_done_i || tmr_q == '0) begin
                    if (ana_q.adc_rel && phase_lt30_i) begin
                        adc_d = PHASE_SAT_LO;
                    end else if (ana_q.adc_rel && phase_gt150_i) begin
                        adc_d = PHASE_SAT_HI;
                    end else begin
                        adc_d = adc_data_i;
                    end
                    state_d = S_IDLE;
                    ana_d   = '0;
                    irq_d   = 1'b1;
                end
            end
            S_SQ: begin
                if (sq_done_i || tmr_q == '0) begin
                    state_d = S_IDLE;
                    ana_d.squelch = 1'b0;
                end
            end
            S_REG: begin
                if (tot_q == '0) begin
                    state_d = S_IDLE;
                    ana_d   = '0;
                    irq_d   = 1'b1;
                end else if (tmr_q == '0) begin
                    if (reg_gap_ok_i || reg_q == REG_CODE_MIN) begin
                        state_d = S_IDLE;
                        ana_d   = '0;
                        irq_d   = 1'b1;
                    end else begin
                        reg_d = reg_q - 1'b1;
                        tmr_d = cyc(STEP_CYC);
                    end
                end
            end
            S_MOD: begin
                if (mod_done_i || tmr_q == '0) begin
                    if (mod_done_i) begin
                        mod_d = mod_result_i;
                    end
                    state_d = S_IDLE;
                    ana_d   = '0;
                    irq_d   = 1'b1;
                end
            end
            S_ANT: begin
                if (ant_done_i || tmr_q == '0) begin
                    if (ant_done_i) begin
                        ant_d = ant_trim_i;
                    end
                    state_d = S_IDLE;
                    ana_d   = '0;
                    irq_d   = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= S_IDLE;
            tmr_q     <= '0;
            tot_q     <= '0;
            mcnt_q    <= '0;
            adc_q     <= BYTE_RST;
            mod_q     <= BYTE_RST;
            ant_q     <= BYTE_RST;
            gain_q    <= BYTE_RST;
            reg_q     <= REG_CODE_RST;
            ana_q     <= '0;
            ack_tgl_q <= 1'b0;
            irq_q     <= 1'b0;
            rej_q     <= 1'b0;
            rclr_q    <= 1'b0;
            agc_q     <= 1'b0;
            arm_q     <= 1'b0;
            tr_q      <= 1'b0;
            rxa_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            tmr_q     <= tmr_d;
            tot_q     <= tot_d;
            mcnt_q    <= mcnt_d;
            adc_q     <= adc_d;
            mod_q     <= mod_d;
            ant_q     <= ant_d;
            gain_q    <= gain_d;
            reg_q     <= reg_d;
            ana_q     <= ana_d;
            ack_tgl_q <= ack_d;
            irq_q     <= irq_d;
            rej_q     <= rej_d;
            rclr_q    <= rclr_d;
            agc_q     <= agc_d;
            arm_q     <= arm_d;
            tr_q      <= tr_d;
            rxa_q     <= rx_active_i;
        end
    end

    // outputs, all registered except supply_sel_o, which passes the two select inputs straight through, and busy_o, decoded from the state
    assign ana_o             = ana_q;
    assign supply_sel_o      = {supply_select_hi_i, supply_select_lo_i};
    assign adc_result_o      = adc_q;
    assign reg_setting_o     = reg_q;
    assign mod_depth_o       = mod_q;
    assign tuning_cap_pins_o = ant_q;
    assign gain_red_o        = gain_q;
    assign transparent_o     = tr_q;
    assign cmd_irq_o         = irq_q;
    assign cmd_reject_o      = rej_q;
    assign rssi_clear_o      = rclr_q;
    assign agc_reset_o       = agc_q;
    assign busy_o            = state_q != S_IDLE;

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_gate_reject: assert property (
        new_cmd && !gate |=> rej_q && !irq_q)
        else $error("command taken without enable");
    a_reject_quiet: assert property (
        rej_d |=> $stable(adc_q) && $stable(reg_q) && !agc_q)
        else $error("rejected command changed state");
    a_meas_bound: assert property (
        mcnt_q <= cyc(MEAS_CYC))
        else $error("measurement overran");
    a_meas_irq: assert property (
        state_q == S_MEAS && state_d == S_IDLE |=> irq_q)
        else $error("no irq after measurement");
    a_phase_sat: assert property (
        state_q == S_MEAS && ana_q.adc_rel && phase_lt30_i &&
        adc_done_i |=> adc_q == PHASE_SAT_LO)
        else $error("phase not saturated");
    a_reg_start: assert property (
        state_q != S_REG ##1 state_q == S_REG |->
        reg_q == REG_CODE_MAX && ana_q.tx_on && ana_q.rx_on)
        else $error("regulator adjust start wrong");
    a_reg_floor: assert property (
        state_q == S_REG |-> reg_q >= REG_CODE_MIN &&
        reg_q <= REG_CODE_MAX)
        else $error("regulator code out of range");
    a_ext_reject: assert property (
        new_cmd && cmd == CMD_ADJ_REG && reg_ext_sel_i
        |=> state_q != S_REG)
        else $error("adjust with external select");
    a_no_sq_irq: assert property (
        state_q == S_SQ && state_d == S_IDLE |=> !irq_q)
        else $error("squelch raised irq");
    a_rssi_edge: assert property (
        $rose(rx_active_i) |=> rclr_q)
        else $error("rssi not cleared");
    a_transp_ss: assert property (
        !ss_s_q |=> !tr_q)
        else $error("transparent without ss");

    c_meas: cover property (state_q == S_MEAS ##1 irq_q);
    c_reg: cover property (state_q == S_REG && reg_d != reg_q);
    c_sq_abort: cover property (state_q == S_SQ && agc_d);
    c_transp: cover property ($rose(tr_q));
endmodule // measure_calibrate_direct_cmds

// >>> tb/host_model.sv
// Purpose: host side model issuing direct commands over the link
// Assumes: link clock runs only during reset and while a frame is under way
// Notes: released command lines carry the inverse of the last word
`timescale 1ns/1ps
module host_model
    import mcal_pkg::*;
(
    // link pins
    output logic      clk_link_o,
    output logic      cmd_stb_o,
    output cmd_word_t cmd_word_o,
    output logic      ss_o,
    input  wire logic link_busy_i
);
    logic run = 1'b1;
    // link clock, 15 ns, odd phase, parked outside frames
    initial begin
        clk_link_o = 1'b0;
        cmd_stb_o = 1'b0;
        cmd_word_o = '0;
        ss_o = 1'b0;
        #3.1;
        forever #7.5 if (run) clk_link_o = ~clk_link_o;
    end
    // a few link edges during reset, then park
    initial #40 run = 1'b0;
    // one command word, strobed for one link cycle
    task automatic send(input cmd_t c, input logic ch);
        run = 1'b1;
        @(negedge clk_link_o);
        for (int i = 0; i < 50 && link_busy_i !== 1'b0; i++)
            @(negedge clk_link_o);
        cmd_stb_o = 1'b1;
        cmd_word_o = '{c, ch};
        @(negedge clk_link_o);
        cmd_stb_o = 1'b0;
        cmd_word_o = cmd_word_t'(~cmd_word_o);
        for (int i = 0; i < 50 && link_busy_i !== 1'b0; i++)
            @(negedge clk_link_o);
        repeat (2) @(negedge clk_link_o);
        run = 1'b0;
    endtask
    // select line held as long as the host wants
    task automatic set_ss(input logic v);
        ss_o = v;
    endtask
endmodule // host_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the direct command sequencer
// Assumes: host model owns the link clock and select line
// Notes: analog feedback echoes the a/d start and calibration controls one cycle later
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import mcal_pkg::*;
    logic clk_sys_i, rst_i, clk_link_i, cmd_stb_i, link_busy_o, ss_i;
    logic op_en_i, osc_ok_i, tx_en_i, rx_en_i, reg_ext_sel_i, mod_wr_i;
    logic supply_select_hi_i, supply_select_lo_i, rx_active_i, sq_done_i;
    logic adc_done_i, phase_lt30_i, phase_gt150_i, reg_gap_ok_i;
    logic mod_done_i, ant_done_i, transparent_o, cmd_irq_o, cmd_reject_o;
    logic rssi_clear_o, agc_reset_o, busy_o;
    logic [7:0] rx_cfg4_gain_i, mod_wdata_i, adc_data_i, mod_result_i;
    logic [7:0] ant_trim_i, adc_result_o, mod_depth_o, tuning_cap_pins_o;
    logic [7:0] gain_red_o, n_irq, n_rej, n_rssi, n_agc, s0;
    logic [3:0] reg_setting_o;
    logic [1:0] supply_sel_o;
    cmd_word_t  cmd_word_i;
    ana_ctrl_t  ana_o, seen;
    int n_mismatch = 0;
    int checks = 0;

    measure_calibrate_direct_cmds #(.SQ_CYC(200), .STEP_CYC(10),
        .REG_CYC(200), .MOD_CYC(30), .ANT_CYC(30)) u_dut (.clk_sys_i,
        .rst_i, .clk_link_i, .cmd_stb_i, .cmd_word_i, .link_busy_o, .ss_i,
        .op_en_i, .osc_ok_i, .tx_en_i, .rx_en_i, .reg_ext_sel_i,
        .supply_select_hi_i, .supply_select_lo_i, .rx_cfg4_gain_i,
        .mod_wr_i, .mod_wdata_i, .rx_active_i, .adc_done_i, .adc_data_i,
        .phase_lt30_i, .phase_gt150_i, .reg_gap_ok_i, .sq_done_i,
        .mod_done_i, .mod_result_i, .ant_done_i, .ant_trim_i, .ana_o,
        .supply_sel_o, .adc_result_o, .reg_setting_o, .mod_depth_o,
        .tuning_cap_pins_o, .gain_red_o, .transparent_o, .cmd_irq_o,
        .cmd_reject_o, .rssi_clear_o, .agc_reset_o, .busy_o);
    host_model u_host (.clk_link_o(clk_link_i), .cmd_stb_o(cmd_stb_i),
        .cmd_word_o(cmd_word_i), .ss_o(ss_i), .link_busy_i(link_busy_o));

    // system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // analog side answers each a/d start and calibration request one cycle later
    always @(negedge clk_sys_i) begin
        adc_done_i <= ana_o.adc_start;
        mod_done_i <= ana_o.mod_cal;
        ant_done_i <= ana_o.ant_cal;
    end
    // event pulse counts, controls seen at conversion start
    always @(posedge clk_sys_i) begin
        n_irq <= n_irq + 8'(cmd_irq_o);
        n_rej <= n_rej + 8'(cmd_reject_o);
        n_rssi <= n_rssi + 8'(rssi_clear_o);
        n_agc <= n_agc + 8'(agc_reset_o);
        if (ana_o.adc_start === 1'b1) seen <= ana_o;
    end
    // send one command, wait for the sequencer, check event counts
    task automatic do_cmd(input cmd_t c, input logic ch, input int w,
                          input int e_irq, input logic [7:0] e_rej);
        logic [7:0] i0;
        logic [7:0] r0;
        i0 = n_irq;
        r0 = n_rej;
        u_host.send(c, ch);
        @(negedge clk_sys_i);
        for (int i = 0; i < w && busy_o !== 1'b0; i++) @(negedge clk_sys_i);
        repeat (3) @(negedge clk_sys_i);
        if (e_irq >= 0) `CHK(n_irq - i0, 8'(e_irq))
        `CHK(n_rej - r0, e_rej)
    endtask
    // measurements: amplitude, phase saturation and mid, supply
    task automatic t_meas();
        adc_data_i = AMP_FULL_CODE;
        do_cmd(CMD_MEAS_AMP, 1'b0, 300, 1, 8'h00);
        `CHK(adc_result_o, AMP_FULL_CODE)
        `CHK({seen.tx_on, seen.amp_det, seen.adc_rel}, 3'b110)
        phase_lt30_i = 1'b1;
        do_cmd(CMD_MEAS_PHASE, 1'b0, 300, 1, 8'h00);
        `CHK(adc_result_o, PHASE_SAT_LO)
        `CHK({seen.tx_on, seen.phase_det, seen.adc_rel}, 3'b111)
        {phase_lt30_i, phase_gt150_i} = 2'b01;
        do_cmd(CMD_MEAS_PHASE, 1'b0, 300, 1, 8'h00);
        `CHK(adc_result_o, PHASE_SAT_HI)
        {phase_gt150_i, adc_data_i} = {1'b0, PHASE_MID};
        do_cmd(CMD_MEAS_PHASE, 1'b0, 300, 1, 8'h00);
        `CHK(adc_result_o, PHASE_MID)
        {supply_select_hi_i, supply_select_lo_i, adc_data_i} = {2'b11, 8'h5a};
        do_cmd(CMD_MEAS_SUP, 1'b0, 300, 1, 8'h00);
        `CHK({supply_sel_o, adc_result_o}, 10'h35a)
        `CHK({seen.sup_div, seen.adc_rel}, 2'b10)
    endtask
    // refused commands: chaining, enable off, oscillator unstable
    task automatic t_reject();
        do_cmd(CMD_MEAS_AMP, 1'b1, 50, 0, 8'h01);
        op_en_i = 1'b0;
        for (int k = 0; k < 10; k++)
            do_cmd(cmd_t'(k), 1'b0, 50, 0, 8'h01);
        {op_en_i, osc_ok_i} = 2'b10;
        do_cmd(CMD_CAL_MOD, 1'b0, 50, 0, 8'h01);
        osc_ok_i = 1'b1;
        `CHK({adc_result_o, mod_depth_o}, 16'h5a00)
    endtask
    // regulator: walk down to minimum, stop at once, external select
    task automatic t_reg();
        do_cmd(CMD_ADJ_REG, 1'b0, 400, 1, 8'h00);
        `CHK(reg_setting_o, REG_CODE_MIN)
        reg_gap_ok_i = 1'b1;
        do_cmd(CMD_ADJ_REG, 1'b0, 400, 1, 8'h00);
        `CHK(reg_setting_o, REG_CODE_MAX)
        reg_ext_sel_i = 1'b1;
        do_cmd(CMD_ADJ_REG, 1'b0, 50, 0, 8'h01);
        reg_ext_sel_i = 1'b0;
    endtask
    // modulation and antenna calibration results
    task automatic t_cal();
        {mod_result_i, ant_trim_i} = 16'h3cc5;
        {mod_wr_i, mod_wdata_i} = {1'b1, 8'h21};
        @(negedge clk_sys_i);
        mod_wr_i = 1'b0;
        `CHK(mod_depth_o, 8'h21)
        do_cmd(CMD_CAL_MOD, 1'b0, 100, 1, 8'h00);
        `CHK(mod_depth_o, 8'h3c)
        do_cmd(CMD_CAL_ANT, 1'b0, 100, 1, 8'h00);
        `CHK(tuning_cap_pins_o, 8'hc5)
    endtask
    // squelch aborted by a chained gain reset; squelch needs rx on
    task automatic t_gain();
        rx_cfg4_gain_i = 8'h2d;
        do_cmd(CMD_SQUELCH, 1'b0, 0, 0, 8'h00);
        `CHK(ana_o.squelch, 1'b1)
        s0 = n_agc;
        do_cmd(CMD_GAIN_RST, 1'b1, 50, 0, 8'h00);
        `CHK({ana_o.squelch, gain_red_o, n_agc - s0}, 17'h0_2d01)
        rx_en_i = 1'b0;
        do_cmd(CMD_SQUELCH, 1'b0, 50, 0, 8'h01);
        {tx_en_i, rx_en_i} = 2'b01;
        do_cmd(CMD_SQUELCH, 1'b0, 50, 0, 8'h01);
        tx_en_i = 1'b1;
        do_cmd(CMD_SQUELCH, 1'b0, 0, 0, 8'h00);
        sq_done_i = 1'b1;
        @(negedge clk_sys_i);
        sq_done_i = 1'b0;
        `CHK({busy_o, ana_o.squelch}, 2'b00)
    endtask
    // receive start and clear command both restart peak hold
    task automatic t_rssi();
        s0 = n_rssi;
        rx_active_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        `CHK(n_rssi - s0, 8'h01)
        do_cmd(CMD_SQUELCH, 1'b0, 250, 0, 8'h00);
        `CHK(ana_o.squelch, 1'b0)
        do_cmd(CMD_CLR_RSSI, 1'b1, 20, 0, 8'h00);
        `CHK(n_rssi - s0, 8'h02)
        rx_active_i = 1'b0;
        do_cmd(CMD_CLR_RSSI, 1'b0, 20, 0, 8'h00);
        `CHK(n_rssi - s0, 8'h02)
    endtask
    // transparent mode follows the select line once armed
    task automatic t_transp();
        do_cmd(CMD_TRANSP, 1'b0, 20, -1, 8'h00);
        `CHK(transparent_o, 1'b0)
        u_host.set_ss(1'b1);
        repeat (4) @(negedge clk_sys_i);
        `CHK(transparent_o, 1'b1)
        u_host.set_ss(1'b0);
        repeat (4) @(negedge clk_sys_i);
        `CHK(transparent_o, 1'b0)
    endtask
    // verdict and end of run
    task automatic final_report();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_i = 1'b1;
        {op_en_i, osc_ok_i, tx_en_i, rx_en_i, reg_ext_sel_i} = 5'h1e;
        {supply_select_hi_i, supply_select_lo_i, mod_wr_i, sq_done_i} = '0;
        {rx_active_i, phase_lt30_i, phase_gt150_i, reg_gap_ok_i} = '0;
        {adc_done_i, mod_done_i, ant_done_i, mod_wdata_i, adc_data_i} = '0;
        {rx_cfg4_gain_i, mod_result_i, ant_trim_i} = '0;
        {n_irq, n_rej, n_rssi, n_agc} = '0;
        repeat (5) @(negedge clk_sys_i);
        `CHK({reg_setting_o, busy_o, cmd_irq_o}, 6'h28)
        rst_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        t_meas();
        t_reject();
        t_reg();
        t_cal();
        t_gain();
        t_rssi();
        t_transp();
        final_report();
    end
    // cut a hang short
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
endmodule // testbench
